/* File: core/dcr_pkg.sv */
// Constants shared by the dual clock and reset unit and its leaf modules.
// Assumes a single 250 MHz bus clock and AXI4-Lite register access.
package dcr_pkg;
	// Clock rate
	localparam int unsigned CLK_PERIOD_NS     = 4;
	// Start-up counters
	localparam int unsigned MAIN_CNT_W        = 14;
	localparam logic [13:0] MAIN_CNT_PRESET   = 14'h3FFF;
	localparam int unsigned SLOW_CNT_W        = 6;
	localparam logic [5:0]  SLOW_CNT_PRESET   = 6'h3F;
	localparam int unsigned MAIN_STEP_DIV     = 2;
	// Prescaler
	localparam int unsigned DIV_W             = 8;
	localparam logic [7:0]  DIV_RESET         = 8'hFF;
	// Slow oscillator loss detection: two nominal slow periods without an edge
	localparam int unsigned SLOW_PERIOD_NS    = 30518;
	localparam int unsigned SLOW_LOSS_PERIODS = 2;
	localparam int unsigned SLOW_LOSS_CYCLES  = (SLOW_LOSS_PERIODS * SLOW_PERIOD_NS) / CLK_PERIOD_NS;
	localparam int unsigned LOSS_CNT_W        = 16;
	// Register map (byte addresses)
	localparam int unsigned ADDR_W            = 8;
	localparam logic [7:0]  OFS_CTRL          = 8'h00;
	localparam logic [7:0]  OFS_DIV           = 8'h04;
	// Control register fields
	localparam int unsigned CTRL_SEL_BIT      = 0;
	localparam int unsigned CTRL_POR_BIT      = 1;
	localparam logic [7:0]  CTRL_USED_MASK    = 8'h03;
	// AXI responses
	localparam logic [1:0]  RESP_OKAY         = 2'h0;
	localparam logic [1:0]  RESP_SLVERR       = 2'h2;
	// Slow clock source
	typedef enum logic [0:0] {
		DCR_SRC_DIVIDED = 1'b0,
		DCR_SRC_CRYSTAL = 1'b1
	} dcr_src_t;
endpackage

/* File: core/dcr_startup_counter.sv */
// Down-counter that times an oscillator start-up.
// Assumes load and step are synchronous to aclk; load has priority over step.
`timescale 1ns/1ps
module dcr_startup_counter #(
	parameter int unsigned W      = 14,
	parameter logic [W-1:0] PRESET = '1
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic         load,
	input  wire logic         step,
	output logic [W-1:0]      count_q,
	output logic              done
);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_q <= PRESET;
		end else if (load) begin
			count_q <= PRESET;
		end else if (step && count_q != '0) begin
			count_q <= count_q - 1'b1;
		end
	end

	// Counting halts at zero, which marks the oscillator stable
	assign done = (count_q == '0);
endmodule

/* File: core/dcr_prescaler.sv */
// Divides the main clock to form the slow clock: (divisor + 1) * 2.
// Assumes main_tick pulses once per main oscillator cycle.
`timescale 1ns/1ps
module dcr_prescaler
	import dcr_pkg::*;
(
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             enable,
	input  wire logic             main_tick,
	input  wire logic [DIV_W-1:0] divisor,
	output logic                  slow_q,
	output logic                  slow_rise
);
	logic [DIV_W-1:0] cnt_q;
	logic             wrap;

	// The programmable stage counts divisor+1 ticks, then the fixed stage toggles
	assign wrap = main_tick && (cnt_q >= divisor);

	always_ff @(posedge aclk) begin
		if (!aresetn || !enable) begin
			cnt_q <= '0;
		end else if (wrap) begin
			cnt_q <= '0;
		end else if (main_tick) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || !enable) begin
			slow_q <= 1'b0;
		end else if (wrap) begin
			slow_q <= ~slow_q;
		end
	end

	assign slow_rise = wrap && !slow_q;
endmodule

/* File: core/dcr_top.sv */
// Dual clock and reset unit: oscillator start-up timing, slow clock selection,
// power-on and external reset, and the two control registers.
// Assumes all inputs are synchronous to aclk and oscillator activity arrives
// as ticks and levels sampled on aclk.
`timescale 1ns/1ps

// Functional notes
// - Main stop halts oscillator, presets counter 3FFF
// - Main release restarts, counts down, step past zero flags good
// - Main good after 32768 main cycles
// - Slow stop disables oscillator, presets counter 3F
// - Slow release starts, counts down, zero flags good
// - Prescaler: fixed halving plus 8-bit divisor
// - Divided mode divides main by (divisor+1)*2
// - Select bit 0, one picks crystal, resets 0
// - Crystal selection turns the prescaler off
// - Crystal used only while it is toggling
// - Power-on presets counter, asserts reset, counts
// - Count zero releases reset unless pin low
// - Low reset pin holds system reset
// - Power-on flag: hardware sets, software only clears
// - Divisor register resets to FF
// - Without crystal main stops only in halt
module dcr_top
	import dcr_pkg::*;
#(
	parameter int unsigned SLOW_LOSS_LIMIT = SLOW_LOSS_CYCLES
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite slave
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Power management side
	input  wire logic              stop_main_req,
	input  wire logic              stop_slow_req,
	input  wire logic              halt_mode,
	output logic                   main_clk_good,
	output logic                   slow_clk_good,
	// Oscillators
	input  wire logic              main_osc_tick,
	input  wire logic              slow_osc_level,
	output logic                   primary_oscillator_en,
	output logic                   slow_osc_en,
	// Slow clock
	output logic                   slow_clk,
	output logic                   slow_clk_from_crystal,
	// Reset
	input  wire logic              power_on_detect,
	input  wire logic              ext_reset_n,
	output logic                   sys_reset_n
);
	// Register state
	logic             sel_q;
	logic             por_flag_q;
	logic [DIV_W-1:0] divisor_field_q;

	// AXI state
	logic              aw_have_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic              w_have_q;
	logic [31:0]       w_data_q;
	logic [3:0]        w_strb_q;
	logic              bvalid_q;
	logic [1:0]        bresp_q;
	logic              rvalid_q;
	logic [31:0]       rdata_q;
	logic [1:0]        rresp_q;
	logic              wr_fire;
	logic              wr_ctrl;
	logic              wr_div;

	// Clock and reset state
	logic              main_half_q;
	logic              main_step;
	logic              main_stop_eff;
	logic [13:0]       main_cnt;
	logic              main_cnt_zero;
	logic              main_good_q;
	logic [13:0]       por_cnt;
	logic              por_done;
	logic [5:0]        slow_cnt;
	logic              slow_prev_q;
	logic              slow_rise;
	logic [LOSS_CNT_W-1:0] loss_cnt_q;
	logic              slow_alive;
	logic              src_sel;
	logic              div_en;
	logic              div_clk;
	logic              slow_clk_q;
	logic              src_q;
	logic              sys_reset_n_q;

	// Byte lane 0 carries every register; other lanes read as zero
	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		is_mapped = (a == OFS_CTRL) || (a == OFS_DIV);
	endfunction

	function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a);
		logic [7:0] b;
		b = 8'h00;
		if (a == OFS_CTRL) begin
			b[CTRL_SEL_BIT] = sel_q;
			b[CTRL_POR_BIT] = por_flag_q;
			b = b & CTRL_USED_MASK;
		end else if (a == OFS_DIV) begin
			b = divisor_field_q;
		end
		read_word = {24'h000000, b};
	endfunction

	// ---------------- AXI4-Lite write path ----------------
	assign s_axi_awready = !aw_have_q && !bvalid_q;
	assign s_axi_wready  = !w_have_q && !bvalid_q;
	assign wr_fire       = aw_have_q && w_have_q && !bvalid_q;
	assign wr_ctrl       = wr_fire && (aw_addr_q == OFS_CTRL) && w_strb_q[0];
	assign wr_div        = wr_fire && (aw_addr_q == OFS_DIV) && w_strb_q[0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			aw_addr_q <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_have_q <= 1'b1;
			aw_addr_q <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_have_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_have_q <= 1'b0;
			w_data_q <= '0;
			w_strb_q <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_have_q <= 1'b1;
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_have_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q  <= is_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp  = bresp_q;

	// ---------------- AXI4-Lite read path ----------------
	assign s_axi_arready = !rvalid_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= '0;
			rresp_q  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rdata_q  <= read_word(s_axi_araddr);
			rresp_q  <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata  = rdata_q;
	assign s_axi_rresp  = rresp_q;

	// ---------------- Registers ----------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sel_q <= 1'b0;
		end else if (wr_ctrl) begin
			sel_q <= w_data_q[CTRL_SEL_BIT];
		end
	end

	// Detection wins over a clear in the same cycle; writing one does nothing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			por_flag_q <= 1'b0;
		end else if (power_on_detect) begin
			por_flag_q <= 1'b1;
		end else if (wr_ctrl && !w_data_q[CTRL_POR_BIT]) begin
			por_flag_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			divisor_field_q <= DIV_RESET;
		end else if (wr_div) begin
			divisor_field_q <= w_data_q[DIV_W-1:0];
		end
	end

	// ---------------- Main oscillator ----------------
	// Without a running crystal the slow clock depends on the main clock
	assign main_stop_eff = stop_main_req && (slow_alive || halt_mode);
	assign primary_oscillator_en = !main_stop_eff;

	// Halve the main tick rate so 14 bits span the full start-up delay
	always_ff @(posedge aclk) begin
		if (!aresetn || main_stop_eff) begin
			main_half_q <= 1'b0;
		end else if (main_osc_tick) begin
			main_half_q <= ~main_half_q;
		end
	end

	assign main_step = main_osc_tick && main_half_q;

	dcr_startup_counter #(
		.W      (MAIN_CNT_W),
		.PRESET (MAIN_CNT_PRESET)
	) u_main_cnt (
		.aclk    (aclk),
		.aresetn (aresetn),
		.load    (main_stop_eff),
		.step    (main_step),
		.count_q (main_cnt),
		.done    (main_cnt_zero)
	);

	// Zero alone is two ticks short of the full delay; one more step past zero completes it
	always_ff @(posedge aclk) begin
		if (!aresetn || main_stop_eff) begin
			main_good_q <= 1'b0;
		end else if (main_step && main_cnt_zero) begin
			main_good_q <= 1'b1;
		end
	end

	assign main_clk_good = main_good_q;

	// ---------------- Power-on and external reset ----------------
	dcr_startup_counter #(
		.W      (MAIN_CNT_W),
		.PRESET (MAIN_CNT_PRESET)
	) u_por_cnt (
		.aclk    (aclk),
		.aresetn (aresetn),
		.load    (power_on_detect),
		.step    (main_step),
		.count_q (por_cnt),
		.done    (por_done)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sys_reset_n_q <= 1'b0;
		end else begin
			sys_reset_n_q <= por_done && !power_on_detect && ext_reset_n;
		end
	end

	assign sys_reset_n = sys_reset_n_q;

	// ---------------- Slow oscillator ----------------
	assign slow_osc_en = !stop_slow_req;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			slow_prev_q <= 1'b0;
		end else begin
			slow_prev_q <= slow_osc_level;
		end
	end

	assign slow_rise = slow_osc_level && !slow_prev_q;

	dcr_startup_counter #(
		.W      (SLOW_CNT_W),
		.PRESET (SLOW_CNT_PRESET)
	) u_slow_cnt (
		.aclk    (aclk),
		.aresetn (aresetn),
		.load    (stop_slow_req),
		.step    (slow_rise),
		.count_q (slow_cnt),
		.done    (slow_clk_good)
	);

	// Loss detector: the crystal counts as toggling while edges keep coming
	always_ff @(posedge aclk) begin
		if (!aresetn || stop_slow_req) begin
			loss_cnt_q <= LOSS_CNT_W'(SLOW_LOSS_LIMIT);
		end else if (slow_osc_level != slow_prev_q) begin
			loss_cnt_q <= '0;
		end else if (loss_cnt_q < LOSS_CNT_W'(SLOW_LOSS_LIMIT)) begin
			loss_cnt_q <= loss_cnt_q + 1'b1;
		end
	end

	assign slow_alive = slow_clk_good && (loss_cnt_q < LOSS_CNT_W'(SLOW_LOSS_LIMIT));

	// ---------------- Slow clock selection ----------------
	assign src_sel = sel_q && slow_alive;
	assign div_en  = !src_sel;

	dcr_prescaler u_prescaler (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.enable    (div_en),
		.main_tick (main_osc_tick),
		.divisor   (divisor_field_q),
		.slow_q    (div_clk),
		.slow_rise ()
	);

	// is the programmer's duty; the divisor is taken as written
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			src_q      <= DCR_SRC_DIVIDED;
			slow_clk_q <= 1'b0;
		end else begin
			src_q      <= src_sel;
			slow_clk_q <= src_sel ? slow_osc_level : div_clk;
		end
	end

	assign slow_clk              = slow_clk_q;
	assign slow_clk_from_crystal = src_q;
endmodule

/* File: sim/dcr_top_monitor.sv */
// Port checker for dcr_top.
// Assumes one aclk domain with synchronous active-low aresetn.
`timescale 1ns/1ps
module dcr_top_monitor (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic stop_main_req,
	input wire logic stop_slow_req,
	input wire logic halt_mode,
	input wire logic main_clk_good,
	input wire logic slow_clk_good,
	input wire logic main_osc_tick,
	input wire logic slow_osc_level,
	input wire logic primary_oscillator_en,
	input wire logic slow_osc_en,
	input wire logic slow_clk,
	input wire logic slow_clk_from_crystal,
	input wire logic power_on_detect,
	input wire logic ext_reset_n,
	input wire logic sys_reset_n
);
	logic [16:0] mcnt_q;
	logic [6:0]  srise_q;
	logic        slv_q;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Main ticks since the oscillator was last enabled
	always_ff @(posedge aclk) begin
		if (!aresetn || !primary_oscillator_en) mcnt_q <= '0;
		else if (main_osc_tick && !mcnt_q[16]) mcnt_q <= mcnt_q + 17'h00001;
	end
	always_ff @(posedge aclk) begin
		slv_q <= slow_osc_level;
	end
	// Crystal rises since the slow stop was released
	always_ff @(posedge aclk) begin
		if (!aresetn || stop_slow_req) srise_q <= '0;
		else if (slow_osc_level && !slv_q && !srise_q[6]) srise_q <= srise_q + 7'h01;
	end
	chk_main_stop_hold: assert property (stop_main_req && halt_mode |-> !primary_oscillator_en ##1 !main_clk_good)
		else $error("main oscillator not held during stop");
	chk_main_good_delay: assert property (main_clk_good |-> mcnt_q >= 17'h08000)
		else $error("main good before start-up delay");
	chk_slow_stop_hold: assert property (stop_slow_req |-> !slow_osc_en ##1 !slow_clk_good)
		else $error("slow oscillator not held during stop");
	chk_slow_good_delay: assert property (slow_clk_good |-> srise_q >= 7'h3F)
		else $error("slow good before 63 crystal rises");
	chk_ext_reset_hold: assert property (!ext_reset_n |=> !sys_reset_n)
		else $error("reset pin low without system reset");
	chk_por_reset_hold: assert property (power_on_detect |=> !sys_reset_n)
		else $error("power-on without system reset");
	chk_reset_release_pin: assert property ($rose(sys_reset_n) |-> $past(ext_reset_n))
		else $error("reset released while pin low");
	chk_crystal_needs_good: assert property (slow_clk_from_crystal |-> $past(slow_clk_good))
		else $error("crystal used while not stable");
	chk_crystal_clk_follow: assert property (slow_clk_from_crystal && $past(slow_clk_from_crystal)
		|-> slow_clk == $past(slow_osc_level))
		else $error("slow clock not taken from crystal");
	cov_main_good: cover property ($rose(main_clk_good));
	cov_crystal_used: cover property ($rose(slow_clk_from_crystal));
	cov_reset_released: cover property ($rose(sys_reset_n));
endmodule

bind dcr_top dcr_top_monitor u_dcr_top_monitor (.aclk(aclk), .aresetn(aresetn), .stop_main_req(stop_main_req),
	.stop_slow_req(stop_slow_req), .halt_mode(halt_mode), .main_clk_good(main_clk_good),
	.slow_clk_good(slow_clk_good), .main_osc_tick(main_osc_tick), .slow_osc_level(slow_osc_level),
	.primary_oscillator_en(primary_oscillator_en), .slow_osc_en(slow_osc_en), .slow_clk(slow_clk),
	.slow_clk_from_crystal(slow_clk_from_crystal), .power_on_detect(power_on_detect),
	.ext_reset_n(ext_reset_n), .sys_reset_n(sys_reset_n));

/* File: sim/dcr_osc_model.sv */
// Oscillator model for the crystal networks.
// Assumes ticks on aclk; a stopped or absent crystal input sits low.
`timescale 1ns/1ps
module dcr_osc_model (
	input  wire logic aclk,
	input  wire logic primary_oscillator_en,
	input  wire logic slow_osc_en,
	input  wire logic crystal_fitted,
	output logic      main_osc_tick,
	output logic      slow_osc_level
);
	logic [1:0] ph_q;
	initial begin
		main_osc_tick = 1'b0;
		slow_osc_level = 1'b0;
		ph_q = 2'h0;
	end
	always @(posedge aclk) begin
		main_osc_tick <= primary_oscillator_en;
	end
	// Crystal toggles every four cycles while running
	always @(posedge aclk) begin
		ph_q <= ph_q + 2'h1;
		if (!slow_osc_en || !crystal_fitted) slow_osc_level <= 1'b0;
		else if (ph_q == 2'h3) slow_osc_level <= !slow_osc_level;
	end
endmodule

/* File: sim/dcr_top_tb.sv */
// Self-checking bench for dcr_top over AXI4-Lite.
// Assumes the oscillator model and a 250 MHz aclk.
`timescale 1ns/1ps
module dcr_top_tb;
	import dcr_pkg::*;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata, d;
	logic [1:0]  bresp, rresp, r;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, q;
	logic stop_main = 1'b0, stop_slow = 1'b1, halt = 1'b0, por = 1'b1, ext_n = 1'b1, xtal = 1'b1;
	logic tick, slvl, osc_en, sosc_en, mgood, sgood, sclk, src, srst_n;
	int mismatches = 0;
	int num_checks = 0;
	int cyc = 0;
	int n;
	dcr_top #(.SLOW_LOSS_LIMIT(50)) u_dcr_top (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .stop_main_req(stop_main), .stop_slow_req(stop_slow), .halt_mode(halt),
		.main_clk_good(mgood), .slow_clk_good(sgood), .main_osc_tick(tick), .slow_osc_level(slvl),
		.primary_oscillator_en(osc_en), .slow_osc_en(sosc_en), .slow_clk(sclk),
		.slow_clk_from_crystal(src), .power_on_detect(por), .ext_reset_n(ext_n), .sys_reset_n(srst_n));
	dcr_osc_model u_dcr_osc_model (.aclk(aclk), .primary_oscillator_en(osc_en), .slow_osc_en(sosc_en),
		.crystal_fitted(xtal), .main_osc_tick(tick), .slow_osc_level(slvl));
	initial begin
		forever #2 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			mismatches = mismatches + 1;
			stop_test();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] e);
		logic ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		awaddr <= a;
		wdata <= {24'h000000, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!ad || !wd) begin
			@(posedge aclk);
			if (awready) ad = 1'b1;
			if (wready) wd = 1'b1;
			awvalid <= !ad;
			wvalid <= !wd;
		end
		do @(posedge aclk); while (!bvalid);
		e = bresp;
		bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		v = rdata;
		e = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask
	// Cycles in one full slow clock period
	task automatic per(output int c);
		logic p;
		repeat (2) begin
			c = 0;
			do begin
				p = sclk;
				@(posedge aclk);
				c++;
			end while (!(sclk && !p));
		end
	endtask
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		por <= 1'b0;
		n = 0;
		while (!srst_n) begin
			@(posedge aclk);
			n++;
		end
		chk(n >= 32767 && n <= 32775, 1);
		chk(mgood, 1);
		rd(OFS_CTRL, d, r);
		chk(d, 32'h00000002);
		rd(OFS_DIV, d, r);
		chk(d, 32'h000000FF);
		wr(OFS_CTRL, 8'h00, r);
		rd(OFS_CTRL, d, r);
		chk(d, 32'h00000000);
		wr(OFS_CTRL, 8'hFE, r);
		rd(OFS_CTRL, d, r);
		chk(d, 32'h00000000);
		wr(8'h08, 8'h01, r);
		chk(r, RESP_SLVERR);
		rd(8'h08, d, r);
		chk(r, RESP_SLVERR);
		ext_n <= 1'b0;
		repeat (3) @(posedge aclk);
		chk(srst_n, 0);
		ext_n <= 1'b1;
		repeat (3) @(posedge aclk);
		chk(srst_n, 1);
		for (int i = 0; i < 4; i++) begin
			wr(OFS_DIV, 8'((1 << ((i == 3) ? 8 : i)) - 1), r);
			per(n);
			per(n);
			chk(n, (1 << ((i == 3) ? 8 : i)) * 2);
		end
		stop_slow <= 1'b0;
		n = 0;
		do begin
			q = slvl;
			@(posedge aclk);
			if (slvl && !q) n++;
		end while (!sgood);
		chk(n >= 63 && n <= 64, 1);
		wr(OFS_CTRL, 8'h01, r);
		repeat (10) @(posedge aclk);
		chk(src, 1);
		per(n);
		chk(n, 8);
		xtal <= 1'b0;
		repeat (70) @(posedge aclk);
		chk(src, 0);
		stop_main <= 1'b1;
		repeat (4) @(posedge aclk);
		chk(osc_en, 1);
		halt <= 1'b1;
		repeat (4) @(posedge aclk);
		chk(osc_en, 0);
		chk(mgood, 0);
		stop_main <= 1'b0;
		halt <= 1'b0;
		n = 0;
		while (!mgood) begin
			@(posedge aclk);
			n++;
		end
		chk(n >= 32768 && n <= 32774, 1);
		stop_test();
	end
endmodule
